// File: hw/light_integration_timing.sv
`timescale 1ns/100ps
// Overview of operation
// - Lower two gain ranges run conversion oscillator at half the upper-range rate.
// - Command register bit 5 picks internal or external integration timing.
// - Internal mode ends integration after 2^m cycles, m from width field.
// - External mode: first sync starts array 1 conversion.
// - Second sync ends array 1 and starts array 2 at once.
// - Third sync ends array 2, publishes result, restarts array 1.
// - External mode counts real elapsed cycles, capped at 65,535.
// - Range-dependent oscillator rate applies in both timing modes.
// - Width 0:0=65,536, 0:1=4,096, 1:0=256, 1:1=16 cycles.
// - 16-bit timer counts each cycle, latched at integration end, two bytes.
// - Data output refreshed after every completed integration.
// - Gain range comes from control register bits 3:2, four ranges.
module light_integration_timing
    import light_timing_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic osc_fast,
    input wire logic [7:0] command_byte,
    input wire logic [7:0] control_byte,
    input wire logic sync_command,
    input wire logic [15:0] adc_count,
    output logic conv_osc_tick,
    output logic array1_active,
    output logic array2_active,
    output logic integration_done,
    output logic [15:0] light_count,
    output logic [7:0] timer_lsb,
    output logic [7:0] timer_msb
);

    typedef struct packed {
        phase_type phase;
        logic mode;
        logic array1;
        logic array2;
        logic [1:0] div;
        logic [15:0] cycles;
        logic tick;
        logic done;
        result_type result;
    } timing_state_type;

    timing_state_type state_reg;
    timing_state_type state_next;
    config_type cfg;
    logic fast_rise;
    logic slow_range;
    logic [15:0] last_count;

    osc_edge_sync u_sync (
        .clock(clock),
        .reset(reset),
        .osc_in(osc_fast),
        .rise_pulse(fast_rise)
    );

    // ==========================================
    // Configuration decode
    always_comb begin
        cfg.external_mode = command_byte[timing_mode_bit];
        cfg.width_code = command_byte[width_lsb +: 2];
        cfg.range_code = control_byte[range_lsb +: 2];
    end

    // Ranges 1 and 2 are codes 0 and 1, so the high bit picks full speed
    assign slow_range = ~cfg.range_code[1];

    always_comb begin
        case (cfg.width_code)
            width_code_16: last_count = width_last_16;
            width_code_12: last_count = width_last_12;
            width_code_8: last_count = width_last_8;
            width_code_4: last_count = width_last_4;
            default: last_count = width_last_16;
        endcase
    end

    // ==========================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        state_next.done = 1'b0;
        // Halving by tick skipping keeps one clock and no gated clocks
        if (fast_rise) begin
            if (slow_range && state_reg.div != range_slow_limit) begin
                state_next.div = state_reg.div + 2'h1;
            end else begin
                state_next.div = 2'h0;
                state_next.tick = 1'b1;
            end
        end
        if (!cfg.external_mode) begin
            if (state_reg.phase == phase_idle) begin
                state_next.phase = phase_array1;
                state_next.cycles = count_reset;
            end else if (state_reg.tick) begin
                if (state_reg.cycles == last_count) begin
                    state_next.done = 1'b1;
                    state_next.result.light_count = adc_count;
                    state_next.result.elapsed_cycle_count = state_reg.cycles;
                    state_next.cycles = count_reset;
                    state_next.phase = phase_array1;
                end else begin
                    state_next.cycles = state_reg.cycles + 16'h0001;
                end
            end
        end else begin
            // Counter saturates; longer periods are the host's to avoid
            if (state_reg.tick && state_reg.phase != phase_idle
                    && state_reg.cycles != count_max) begin
                state_next.cycles = state_reg.cycles + 16'h0001;
            end
            if (sync_command) begin
                case (state_reg.phase)
                    phase_idle: begin
                        state_next.phase = phase_array1;
                        state_next.cycles = count_reset;
                    end
                    phase_array1: begin
                        state_next.phase = phase_array2;
                    end
                    phase_array2: begin
                        state_next.done = 1'b1;
                        state_next.result.light_count = adc_count;
                        state_next.result.elapsed_cycle_count = state_reg.cycles;
                        state_next.phase = phase_array1;
                        state_next.cycles = count_reset;
                    end
                    default: state_next.phase = phase_idle;
                endcase
            end
        end
        // Mode change abandons the current measurement
        if (cfg.external_mode != state_reg.mode) begin
            state_next.phase = phase_idle;
            state_next.cycles = count_reset;
        end
        state_next.mode = cfg.external_mode;
        // Phase flags are registered so the outputs leave straight from flops
        state_next.array1 = (state_next.phase == phase_array1);
        state_next.array2 = (state_next.phase == phase_array2);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= '{phase: phase_idle, mode: 1'b0, array1: 1'b0, array2: 1'b0,
                div: 2'h0, cycles: count_reset, tick: 1'b0, done: 1'b0, result: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign conv_osc_tick = state_reg.tick;
    assign array1_active = state_reg.array1;
    assign array2_active = state_reg.array2;
    assign integration_done = state_reg.done;
    assign light_count = state_reg.result.light_count;
    assign timer_lsb = state_reg.result.elapsed_cycle_count[7:0];
    assign timer_msb = state_reg.result.elapsed_cycle_count[15:8];

    // ==========================================
    // Checks
    property p_int_restart;
        @(posedge clock) disable iff (reset)
        (state_reg.done && !cfg.external_mode && $stable(cfg.external_mode))
            |-> (state_reg.cycles == count_reset) && array1_active;
    endproperty
    a_int_restart: assert property (p_int_restart) else $error("no restart");

    property p_sync_second;
        @(posedge clock) disable iff (reset)
        (cfg.external_mode && state_reg.mode && sync_command && array1_active)
            |=> array2_active;
    endproperty
    a_sync_second: assert property (p_sync_second) else $error("array 2 not started");

    property p_sync_third;
        @(posedge clock) disable iff (reset)
        (cfg.external_mode && state_reg.mode && sync_command && array2_active)
            |=> integration_done && array1_active && state_reg.cycles == count_reset;
    endproperty
    a_sync_third: assert property (p_sync_third) else $error("third sync wrong");

    property p_sync_first;
        @(posedge clock) disable iff (reset)
        (cfg.external_mode && state_reg.mode && sync_command
            && state_reg.phase == phase_idle) |=> array1_active;
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("array 1 not started");

    property p_timer_latch;
        @(posedge clock) disable iff (reset)
        integration_done |-> {timer_msb, timer_lsb} == $past(state_reg.cycles);
    endproperty
    a_timer_latch: assert property (p_timer_latch) else $error("timer latch wrong");

    property p_data_refresh;
        @(posedge clock) disable iff (reset)
        integration_done |-> light_count == $past(adc_count);
    endproperty
    a_data_refresh: assert property (p_data_refresh) else $error("data not refreshed");

    property p_slow_tick;
        @(posedge clock) disable iff (reset)
        (fast_rise && slow_range && state_reg.div == 2'h0) |=> !conv_osc_tick;
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow range not halved");

    property p_fast_tick;
        @(posedge clock) disable iff (reset)
        (fast_rise && !slow_range) |=> conv_osc_tick;
    endproperty
    a_fast_tick: assert property (p_fast_tick) else $error("fast range tick missing");

    property p_saturate;
        @(posedge clock) disable iff (reset)
        (cfg.external_mode && state_reg.mode && state_reg.cycles == count_max && !sync_command)
            |=> state_reg.cycles == count_max || $changed(cfg.external_mode);
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");

    property p_int_end;
        @(posedge clock) disable iff (reset)
        (!cfg.external_mode && !state_reg.mode && state_reg.tick
            && state_reg.phase != phase_idle && state_reg.cycles == last_count)
            |=> integration_done;
    endproperty
    a_int_end: assert property (p_int_end) else $error("internal end missed");

    c_int_done: cover property (@(posedge clock) !cfg.external_mode && integration_done);
    c_ext_done: cover property (@(posedge clock) cfg.external_mode && integration_done);
    c_slow: cover property (@(posedge clock) slow_range && conv_osc_tick);

endmodule

// File: hw/light_timing_pkg.sv
package light_timing_pkg;

    // ==========================================
    // Command register fields (address 0x00)
    localparam logic [7:0] command_reg_addr = 8'h00;
    localparam int timing_mode_bit = 5;
    localparam int width_lsb = 0;

    // ==========================================
    // Control register fields (address 0x01)
    localparam logic [7:0] control_reg_addr = 8'h01;
    localparam int range_lsb = 2;

    // ==========================================
    // Width field codes
    localparam logic [1:0] width_code_16 = 2'h0;
    localparam logic [1:0] width_code_12 = 2'h1;
    localparam logic [1:0] width_code_8 = 2'h2;
    localparam logic [1:0] width_code_4 = 2'h3;

    // Last counter index per width code, one below the cycle count
    localparam logic [15:0] width_last_16 = 16'hFFFF;
    localparam logic [15:0] width_last_12 = 16'h0FFF;
    localparam logic [15:0] width_last_8 = 16'h00FF;
    localparam logic [15:0] width_last_4 = 16'h000F;

    // Highest count value in a 16-bit counter
    localparam logic [15:0] count_max = 16'hFFFF;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [15:0] data_reset = 16'h0000;

    // Half-rate divider toggles on each fast tick
    localparam logic [1:0] range_slow_limit = 2'h1;

    // Input synchroniser depth for the oscillator edge
    localparam int sync_depth = 3;

    typedef enum logic [1:0] {
        phase_idle,
        phase_array1,
        phase_array2
    } phase_type;

    // Settings presented by the register bank
    typedef struct packed {
        logic external_mode;
        logic [1:0] width_code;
        logic [1:0] range_code;
    } config_type;

    // Published result
    typedef struct packed {
        logic [15:0] light_count;
        logic [15:0] elapsed_cycle_count;
    } result_type;

endpackage

// File: hw/osc_edge_sync.sv
`timescale 1ns/100ps
module osc_edge_sync
    import light_timing_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic osc_in,
    output logic rise_pulse
);

    typedef struct packed {
        logic [sync_depth-1:0] stages;
        logic [1:0] fill;
        logic level;
        logic rise;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    // ==========================================
    // Edge detect
    // Only the second and third stages are compared, never the first
    always_comb begin
        state_next = state_reg;
        state_next.stages = {state_reg.stages[sync_depth-2:0], osc_in};
        state_next.rise = 1'b0;
        if (state_reg.fill != 2'(sync_depth)) begin
            // Priming takes the baseline, so a pin already high at reset is no edge
            state_next.fill = state_reg.fill + 2'h1;
            state_next.level = state_reg.stages[1];
        end else if (state_reg.stages[1] == state_reg.stages[2]) begin
            state_next.level = state_reg.stages[2];
            state_next.rise = state_reg.stages[2] & ~state_reg.level;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_pulse = state_reg.rise;

endmodule

// File: tb/host_sync_model.sv
`timescale 1ns/100ps
module host_sync_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic go,
    input wire logic [15:0] gap,
    output logic sync_command,
    output logic busy
);

    // ==========================================
    // Host side of external timing
    // Three one-cycle syncs, the two gaps identical, so both sub-intervals match
    // Caller keeps gap short: the device counter cannot hold more than 65,535 ticks
    initial begin
        sync_command = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clock);
            if (go && !reset) begin
                busy <= 1'b1;
                for (int i = 0; i < 3; i++) begin
                    sync_command <= 1'b1;
                    @(posedge clock);
                    sync_command <= 1'b0;
                    if (i < 2) begin
                        repeat (int'(gap) - 1) @(posedge clock);
                    end
                end
                busy <= 1'b0;
            end
        end
    end

endmodule

// File: tb/tb_light_integration_timing.sv
`timescale 1ns/100ps
module tb_light_integration_timing;
    import light_timing_pkg::*;

    // ==========================================
    // Signals
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic osc_fast = 1'b0;
    logic [7:0] command_byte = 8'h00;
    logic [7:0] control_byte = 8'h00;
    logic [15:0] adc_count = 16'h0000;
    logic [15:0] gap = 16'h0190;
    logic go = 1'b0;
    logic sync_command;
    logic busy;
    logic conv_osc_tick;
    logic array1_active;
    logic array2_active;
    logic integration_done;
    logic [15:0] light_count;
    logic [7:0] timer_lsb;
    logic [7:0] timer_msb;
    int error_cnt = 0;
    int checks_done = 0;

    // ==========================================
    // Clocks and instances
    initial begin
        forever #25 clock = ~clock;
    end

    // Oscillator runs free at eight clock periods, its edges a fixed 12 ns after a clock edge
    initial begin
        #37;
        forever #200 osc_fast <= ~osc_fast;
    end

    light_integration_timing uut (.clock(clock), .reset(reset), .osc_fast(osc_fast),
        .command_byte(command_byte), .control_byte(control_byte),
        .sync_command(sync_command), .adc_count(adc_count), .conv_osc_tick(conv_osc_tick),
        .array1_active(array1_active), .array2_active(array2_active),
        .integration_done(integration_done), .light_count(light_count),
        .timer_lsb(timer_lsb), .timer_msb(timer_msb));

    host_sync_model host (.clock(clock), .reset(reset), .go(go), .gap(gap),
        .sync_command(sync_command), .busy(busy));

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Counts edges up to the next result pulse, bounded so a dead design cannot hang
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (integration_done !== 1'b1 && n < 40000);
        if (integration_done !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t no result pulse", $time);
            end_of_test();
        end
    endtask

    // Reset between scenarios so every run starts from a known phase
    task automatic restart(input logic [1:0] rng, input logic [7:0] cmd);
        @(posedge clock);
        reset <= 1'b1;
        control_byte <= {4'h0, rng, 2'h0};
        command_byte <= cmd;
        adc_count <= {cmd, 6'h15, rng};
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask

    // ==========================================
    // Scenarios
    // Second interval is measured: the first one starts at an arbitrary oscillator phase
    task automatic internal_run(input logic [1:0] rng, input logic [1:0] wid, input int period,
            input logic [15:0] tmax);
        int n;
        restart(rng, {6'h00, wid});
        wait_done(n);
        // A fresh input before the next latch shows every integration refreshes the data
        adc_count <= ~adc_count;
        wait_done(n);
        check(16'(n), 16'(period), "internal spacing");
        check(light_count, adc_count, "internal result");
        check({timer_msb, timer_lsb}, tmax, "internal timer");
    endtask

    // Long width: only the first result is awaited, to keep the run short
    task automatic internal_long(input logic [1:0] rng, input logic [1:0] wid,
            input logic [15:0] tmax);
        int n;
        restart(rng, {6'h00, wid});
        wait_done(n);
        check(light_count, adc_count, "long result");
        check({timer_msb, timer_lsb}, tmax, "long timer");
    endtask

    task automatic ext_run(input logic [1:0] rng, input int ticks_per);
        int n;
        restart(rng, 8'h20);
        repeat (4) @(posedge clock);
        // Syncs are aligned to the oscillator so the elapsed tick count is exact
        @(posedge osc_fast);
        @(posedge clock);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (200) @(posedge clock);
        check({14'h0, array2_active, array1_active}, 16'h0001, "first array");
        repeat (400) @(posedge clock);
        check({14'h0, array2_active, array1_active}, 16'h0002, "second array");
        wait_done(n);
        check(light_count, adc_count, "external result");
        check({timer_msb, timer_lsb}, 16'(800 / ticks_per), "elapsed ticks");
        @(posedge clock);
        check({14'h0, array2_active, array1_active}, 16'h0001, "restart");
        // The tick train is periodic, so any window of whole periods holds an exact count
        n = 0;
        repeat (160) begin
            @(posedge clock);
            if (conv_osc_tick === 1'b1) begin
                n++;
            end
        end
        check(16'(n), 16'(160 / ticks_per), "tick rate");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        internal_run(2'h3, 2'h3, 128, 16'h000F);
        internal_run(2'h2, 2'h3, 128, 16'h000F);
        internal_run(2'h1, 2'h3, 256, 16'h000F);
        internal_run(2'h0, 2'h3, 256, 16'h000F);
        internal_run(2'h3, 2'h2, 2048, 16'h00FF);
        internal_run(2'h0, 2'h2, 4096, 16'h00FF);
        internal_long(2'h3, 2'h1, 16'h0FFF);
        ext_run(2'h3, 8);
        ext_run(2'h0, 16);
        end_of_test();
    end

    initial begin
        #4000000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

endmodule
